// File: core/input_debounce.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------------
// Three-input filter: a change passes after three stable tick periods.
// ------------------------------------------------------------------------
module input_debounce (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic bypass_i,
  input wire logic [2:0] raw_i,
  output logic [2:0] clean_o
);
  import tcqd_pkg::*;

  typedef struct packed {
    logic [2:0] clean;
    logic [2:0][1:0] stable;
  } deb_state_type;

  deb_state_type s; // Current state.
  deb_state_type next_s; // Next state.

  // A glitch shorter than the window restarts the count and never passes.
  always_comb begin
    next_s = s;
    for (int i = 0; i < 3; i++) begin
      if (bypass_i || raw_i[i] == s.clean[i]) begin
        next_s.clean[i] = raw_i[i];
        next_s.stable[i] = 2'h0;
      end else if (tick_i) begin
        if (s.stable[i] + 2'h1 == DEBOUNCE_PERIODS) begin
          next_s.clean[i] = raw_i[i];
          next_s.stable[i] = 2'h0;
        end else begin
          next_s.stable[i] = s.stable[i] + 2'h1;
        end
      end
    end
  end

  // Register the state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign clean_o = s.clean;
endmodule

// File: core/tcqd_pkg.sv
package tcqd_pkg;

  // ----------------------------------------------------------------------
  // Register indices; the byte address on the bus is four times the index.
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_TIMER_CTRL = 16'hA050;
  localparam logic [15:0] IDX_TIMER_FLAGS = 16'hA051;
  localparam logic [15:0] IDX_CAPT_CFG = 16'hA052;
  localparam logic [15:0] IDX_PERIOD_LO = 16'hA054;
  localparam logic [15:0] IDX_PERIOD_HI = 16'hA055;
  localparam logic [15:0] IDX_COMPARE_LO = 16'hA056;
  localparam logic [15:0] IDX_COMPARE_HI = 16'hA057;
  localparam logic [15:0] IDX_CAPT_R_LO = 16'hA060;
  localparam logic [15:0] IDX_CAPT_R_HI = 16'hA061;
  localparam logic [15:0] IDX_CAPT_F_LO = 16'hA062;
  localparam logic [15:0] IDX_CAPT_F_HI = 16'hA063;
  localparam logic [15:0] IDX_QUAD_CFG = 16'hA070;
  localparam logic [15:0] IDX_QUAD_STAT = 16'hA071;
  localparam logic [15:0] IDX_QUAD_IRQ = 16'hA072;
  localparam logic [15:0] IDX_QUAD_CNT_LO = 16'hA074;
  localparam logic [15:0] IDX_QUAD_CNT_HI = 16'hA075;
  localparam logic [15:0] IDX_QUAD_MAX_LO = 16'hA076;
  localparam logic [15:0] IDX_QUAD_MAX_HI = 16'hA077;

  // ----------------------------------------------------------------------
  // Reset values and fixed counts.
  // ----------------------------------------------------------------------
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] QUAD_RELOAD = 16'h8000;
  localparam logic [1:0] DEBOUNCE_PERIODS = 2'h3;

  // Bit positions inside the capture configuration register.
  localparam int CAP_TERM_IRQ_EN = 7;
  localparam int CAP_CMP_IRQ_EN = 6;
  localparam int CAP_COUPLE_EN = 5;
  localparam int CAP_CLR_ON_CAPT = 4;
  localparam int CAP_EXT_RISE_EN = 3;
  localparam int CAP_EXT_FALL_EN = 2;
  localparam int CAP_SW_RISE = 1;
  localparam int CAP_SW_FALL = 0;

  // Bit positions inside the decoder status register.
  localparam int QS_DIR = 7;
  localparam int QS_ERR = 6;
  localparam int QS_TERM = 3;
  localparam int QS_INDEX = 2;
  localparam int QS_DIRCHG = 1;
  localparam int QS_COUNT = 0;

  // Decoder counting modes.
  typedef enum logic [1:0] {
    QM_OFF = 2'h0,
    QM_1X = 2'h1,
    QM_2X = 2'h2,
    QM_4X = 2'h3
  } quad_mode_type;

  // Bus answer states, Gray coded.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK = 2'h1
  } bus_state_type;

  // Hardware set wins over a software write of zero.
  function automatic logic flag_update(input logic old, input logic wr,
                                       input logic wbit, input logic set);
    flag_update = (wr ? (old & wbit) : old) | set;
  endfunction

  // Position of a phase pair along the up sequence 00, 10, 11, 01.
  function automatic logic [1:0] phase_pos(input logic [1:0] ab);
    phase_pos = {ab[0], ab[1] ^ ab[0]};
  endfunction

endpackage

// File: core/tick_divider.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------------
// Free running divider: one-cycle tick every (mask + 1) clocks.
// ------------------------------------------------------------------------
module tick_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] mask_i,
  output logic tick_o
);
  import tcqd_pkg::*;

  typedef struct packed {
    logic [7:0] count;
    logic tick;
  } div_state_type;

  div_state_type s; // Current state.
  div_state_type next_s; // Next state.

  // The mask must be all ones in its low bits, so ticks stay evenly spaced.
  always_comb begin
    next_s = s;
    next_s.count = s.count + 8'h01;
    next_s.tick = ((s.count & mask_i) == mask_i);
  end

  // Register the state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;
endmodule

// File: core/timer_capture_quad_decoder.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Timer wraps at period; compare match; buffered values.
// - Terminal and compare flags set; software writes zero.
// - External rising edge captures when enabled.
// - External falling edge captures when enabled.
// - Software rise trigger captures, then self-clears.
// - Software fall trigger captures, then self-clears.
// - All capture sources may act together.
// - Period written high then low; low commits.
// - Period locations read back live timer count.
// - Compare written high then low; low commits.
// - Signed decoder count, reload 0x8000, 15-bit max.
// - Decoder reloads on index or terminal count.
// - Decoder sample rate clock over 4/16/64/256.
// - Direction reversal sets flag, optional interrupt.
// - Terminal at max going up, zero down.
// - Counter readable live; writable only while disabled.
// - Decoder index or terminal can capture timer.
module timer_capture_quad_decoder (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [17:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic ext_capture_i,
  input wire logic quad_in_a_i,
  input wire logic quad_in_b_i,
  input wire logic quad_index_i,
  output logic term_count_event_o,
  output logic compare_match_event_o,
  output logic timer_irq_o,
  output logic quad_irq_o
);
  import tcqd_pkg::*;

  // ----------------------------------------------------------------------
  // State of the whole block.
  // ----------------------------------------------------------------------
  typedef struct packed {
    bus_state_type bus;
    logic [7:0] rdata;
    logic timer_en;
    logic [15:0] count;
    logic [15:0] period_act;
    logic [15:0] period_buf;
    logic [7:0] period_hi;
    logic [15:0] compare_act;
    logic [15:0] compare_buf;
    logic [7:0] compare_hi;
    logic term_flag;
    logic compare_flag;
    logic term_pulse;
    logic cmp_pulse;
    logic [7:0] capt_cfg;
    logic [15:0] capt_r;
    logic [15:0] capt_f;
    logic ext_prev;
    logic [7:0] q_cfg;
    logic [7:0] q_stat;
    logic [7:0] q_irq;
    logic [15:0] q_count;
    logic [15:0] q_max;
    logic [1:0] q_prev_ab;
    logic q_prev_idx;
  } core_state_type;

  core_state_type s; // Current state.
  core_state_type next_s; // Next state.

  logic q_tick; // Decoder sample strobe.
  logic deb_tick; // Debounce sample strobe.
  logic [7:0] q_mask; // Decoder divider mask.
  logic [7:0] deb_mask; // Debounce divider mask.
  logic [2:0] clean; // Filtered index, A and B.

  // ----------------------------------------------------------------------
  // Dividers and input filter.
  // ----------------------------------------------------------------------

  // Scale codes 00 to 11 give 4, 16, 64 and 256 clocks per sample.
  always_comb begin
    case (s.q_cfg[5:4])
      2'h0: q_mask = 8'h03;
      2'h1: q_mask = 8'h0F;
      2'h2: q_mask = 8'h3F;
      default: q_mask = 8'hFF;
    endcase
    deb_mask = 8'((9'h001 << s.q_cfg[2:0]) - 9'h001);
  end

  tick_divider quad_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mask_i(q_mask),
    .tick_o(q_tick)
  );

  tick_divider deb_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mask_i(deb_mask),
    .tick_o(deb_tick)
  );

  input_debounce deb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(deb_tick),
    .bypass_i(s.q_cfg[2:0] == 3'h0),
    .raw_i({quad_index_i, quad_in_a_i, quad_in_b_i}),
    .clean_o(clean)
  );

  // ----------------------------------------------------------------------
  // Working signals of the next-state logic.
  // ----------------------------------------------------------------------
  logic [15:0] idx; // Register index from the bus address.
  logic wr; // Write takes effect this edge.
  logic [7:0] wd; // Write data byte.
  logic [1:0] ab; // Phase pair after optional swap.
  logic [1:0] delta; // Phase step along the up sequence.
  logic q_on; // Decoder enabled.
  logic up; // One step up.
  logic dn; // One step down.
  logic step; // Counter moves this sample.
  logic idx_lvl; // Gated index input.
  logic idx_ev; // Index event.
  logic term_ev; // Decoder terminal event.
  logic [15:0] q_nc; // Counter after the step.
  logic [15:0] q_abs; // Magnitude of that value.
  logic cap_r; // Capture into the rise register.
  logic cap_f; // Capture into the fall register.
  logic t_wrap; // Timer reached its period.
  logic t_match; // Timer reached its compare value.

  // ----------------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    idx = adr_i[17:2];
    wd = dat_i[7:0];
    wr = cyc_i && stb_i && we_i && sel_i[0] && (s.bus == BUS_ACK);

    // Decoder sampling; prev_ab tracks even when off so enabling is clean.
    ab = s.q_cfg[3] ? {clean[0], clean[1]} : clean[1:0];
    q_on = (s.q_cfg[7:6] != QM_OFF);
    delta = phase_pos(ab) - phase_pos(s.q_prev_ab);
    up = q_tick && q_on && (delta == 2'h1);
    dn = q_tick && q_on && (delta == 2'h3);
    case (s.q_cfg[7:6])
      QM_4X: step = up || dn;
      QM_2X: step = (up || dn) && (ab[1] == ab[0]);
      QM_1X: step = (up && ab == 2'h0) || (dn && s.q_prev_ab == 2'h0);
      default: step = 1'b0;
    endcase
    idx_lvl = clean[2] && s.q_irq[2];
    if (s.q_cfg[7:6] == QM_1X) begin
      idx_ev = q_tick && idx_lvl && !s.q_prev_idx;
    end else begin
      // The selected transition must coincide with the index level.
      idx_ev = idx_lvl && ((up && s.q_prev_ab == s.q_irq[1:0]) ||
               (dn && ab == s.q_irq[1:0]));
    end
    q_nc = up ? s.q_count + 16'h0001 : s.q_count - 16'h0001;
    q_abs = q_nc[15] ? 16'(-q_nc) : q_nc;
    term_ev = step && (up ? (q_abs == {1'b0, s.q_max[14:0]}) :
              (q_nc == WORD_RESET));
    if (q_tick) begin
      next_s.q_prev_ab = ab;
      next_s.q_prev_idx = idx_lvl;
    end

    // Capture sources are independent and may coincide.
    cap_r = (s.capt_cfg[CAP_EXT_RISE_EN] && ext_capture_i &&
             !s.ext_prev) ||
            (s.capt_cfg[CAP_COUPLE_EN] && (idx_ev || term_ev)) ||
            s.capt_cfg[CAP_SW_RISE];
    cap_f = (s.capt_cfg[CAP_EXT_FALL_EN] && !ext_capture_i &&
             s.ext_prev) ||
            s.capt_cfg[CAP_SW_FALL];
    next_s.ext_prev = ext_capture_i;
    if (cap_r) begin
      next_s.capt_r = s.count;
    end
    if (cap_f) begin
      next_s.capt_f = s.count;
    end
    next_s.capt_cfg[CAP_SW_RISE] = 1'b0;
    next_s.capt_cfg[CAP_SW_FALL] = 1'b0;

    // Timer: wrap at period and load the buffered values at that point.
    t_wrap = s.timer_en && (s.count == s.period_act);
    t_match = s.timer_en && (s.count == s.compare_act);
    if (!s.timer_en) begin
      next_s.period_act = s.period_buf;
      next_s.compare_act = s.compare_buf;
    end else if (t_wrap) begin
      next_s.count = WORD_RESET;
      next_s.period_act = s.period_buf;
      next_s.compare_act = s.compare_buf;
    end else begin
      next_s.count = s.count + 16'h0001;
    end
    if (s.capt_cfg[CAP_CLR_ON_CAPT] && (cap_r || cap_f)) begin
      next_s.count = WORD_RESET;
    end
    next_s.term_pulse = t_wrap;
    next_s.cmp_pulse = t_match;

    // Decoder counter: reload takes priority over the step.
    if ((s.q_stat[4] && idx_ev) || (s.q_stat[5] && term_ev)) begin
      next_s.q_count = QUAD_RELOAD;
    end else if (step) begin
      next_s.q_count = q_nc;
    end
    if (up) begin
      next_s.q_stat[QS_DIR] = 1'b1;
    end else if (dn) begin
      next_s.q_stat[QS_DIR] = 1'b0;
    end

    // Register writes; hardware-set flags win over software clears.
    next_s.term_flag = flag_update(s.term_flag,
      wr && idx == IDX_TIMER_FLAGS, wd[1], t_wrap);
    next_s.compare_flag = flag_update(s.compare_flag,
      wr && idx == IDX_TIMER_FLAGS, wd[0], t_match);
    next_s.q_stat[QS_ERR] = flag_update(s.q_stat[QS_ERR],
      wr && idx == IDX_QUAD_STAT, wd[QS_ERR],
      q_tick && q_on && delta == 2'h2);
    next_s.q_stat[QS_TERM] = flag_update(s.q_stat[QS_TERM],
      wr && idx == IDX_QUAD_STAT, wd[QS_TERM], term_ev);
    next_s.q_stat[QS_INDEX] = flag_update(s.q_stat[QS_INDEX],
      wr && idx == IDX_QUAD_STAT, wd[QS_INDEX], idx_ev);
    next_s.q_stat[QS_DIRCHG] = flag_update(s.q_stat[QS_DIRCHG],
      wr && idx == IDX_QUAD_STAT, wd[QS_DIRCHG],
      (up && !s.q_stat[QS_DIR]) || (dn && s.q_stat[QS_DIR]));
    next_s.q_stat[QS_COUNT] = flag_update(s.q_stat[QS_COUNT],
      wr && idx == IDX_QUAD_STAT, wd[QS_COUNT], step);
    if (wr) begin
      case (idx)
        IDX_TIMER_CTRL: next_s.timer_en = wd[0];
        IDX_CAPT_CFG: next_s.capt_cfg = wd | (s.capt_cfg & 8'h03);
        IDX_PERIOD_HI: next_s.period_hi = wd;
        IDX_PERIOD_LO: next_s.period_buf = {s.period_hi, wd};
        IDX_COMPARE_HI: next_s.compare_hi = wd;
        IDX_COMPARE_LO: next_s.compare_buf = {s.compare_hi, wd};
        IDX_QUAD_CFG: next_s.q_cfg = wd;
        IDX_QUAD_STAT: next_s.q_stat[5:4] = wd[5:4];
        IDX_QUAD_IRQ: next_s.q_irq = wd;
        IDX_QUAD_CNT_LO: begin
          if (!q_on) begin
            next_s.q_count[7:0] = wd;
          end
        end
        IDX_QUAD_CNT_HI: begin
          if (!q_on) begin
            next_s.q_count[15:8] = wd;
          end
        end
        IDX_QUAD_MAX_LO: next_s.q_max[7:0] = wd;
        IDX_QUAD_MAX_HI: next_s.q_max[15:8] = wd;
        default: begin
        end
      endcase
    end

    // Bus answer: data is latched with the acknowledge, one cycle later.
    case (s.bus)
      BUS_IDLE: begin
        if (cyc_i && stb_i) begin
          next_s.bus = BUS_ACK;
          case (idx)
            IDX_TIMER_CTRL: next_s.rdata = {7'h00, s.timer_en};
            IDX_TIMER_FLAGS: next_s.rdata =
              {6'h00, s.term_flag, s.compare_flag};
            IDX_CAPT_CFG: next_s.rdata = s.capt_cfg;
            IDX_PERIOD_LO: next_s.rdata = s.count[7:0];
            IDX_PERIOD_HI: next_s.rdata = s.count[15:8];
            IDX_COMPARE_LO: next_s.rdata = s.compare_buf[7:0];
            IDX_COMPARE_HI: next_s.rdata = s.compare_buf[15:8];
            IDX_CAPT_R_LO: next_s.rdata = s.capt_r[7:0];
            IDX_CAPT_R_HI: next_s.rdata = s.capt_r[15:8];
            IDX_CAPT_F_LO: next_s.rdata = s.capt_f[7:0];
            IDX_CAPT_F_HI: next_s.rdata = s.capt_f[15:8];
            IDX_QUAD_CFG: next_s.rdata = s.q_cfg;
            IDX_QUAD_STAT: next_s.rdata = s.q_stat;
            IDX_QUAD_IRQ: next_s.rdata = s.q_irq;
            IDX_QUAD_CNT_LO: next_s.rdata = s.q_count[7:0];
            IDX_QUAD_CNT_HI: next_s.rdata = s.q_count[15:8];
            IDX_QUAD_MAX_LO: next_s.rdata = s.q_max[7:0];
            IDX_QUAD_MAX_HI: next_s.rdata = s.q_max[15:8];
            default: next_s.rdata = BYTE_RESET;
          endcase
        end
      end
      BUS_ACK: next_s.bus = BUS_IDLE;
      default: next_s.bus = BUS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign ack_o = (s.bus == BUS_ACK);
  assign dat_o = {24'h000000, s.rdata};
  assign term_count_event_o = s.term_pulse;
  assign compare_match_event_o = s.cmp_pulse;
  assign timer_irq_o = (s.capt_cfg[CAP_TERM_IRQ_EN] && s.term_flag) ||
                       (s.capt_cfg[CAP_CMP_IRQ_EN] && s.compare_flag);
  assign quad_irq_o = |(s.q_irq[7:3] & {s.q_stat[QS_TERM],
                        s.q_stat[QS_INDEX], s.q_stat[QS_DIRCHG],
                        s.q_stat[QS_COUNT], s.q_stat[QS_ERR]});
endmodule

// File: core/unused_placeholder_note.sv
`timescale 1ns/1ps

// File: dv/quad_encoder_model.sv
`timescale 1ns/1ps

// Encoder: a step moves the phases one place along 00, 10, 11, 01.
// A jump moves two places, so both phases change at once on purpose.
module quad_encoder_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_up_i,
  input wire logic step_dn_i,
  input wire logic jump_i,
  output logic a_o,
  output logic b_o
);
  logic [1:0] pos; // Place along the up sequence.
  // Moves land just after an edge, as a shaft edge would.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos <= 2'h0;
    end else if (step_up_i) begin
      pos <= pos + 2'h1;
    end else if (step_dn_i) begin
      pos <= pos - 2'h1;
    end else if (jump_i) begin
      pos <= pos + 2'h2;
    end
  end
  assign a_o = pos[0] ^ pos[1];
  assign b_o = pos[1];
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps

// Self-checking bench: registers, timer, capture and decoder.
module tb;
  import tcqd_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, ext_i;
  logic a, b, tc, cc, tirq, qirq, up, dn, jmp, ix;
  logic [17:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic [7:0] r; // Last byte read.
  logic [15:0] v, c; // Last word read and a saved count.
  int bad_count, tests_run;

  timer_capture_quad_decoder dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .ext_capture_i(ext_i),
    .quad_in_a_i(a), .quad_in_b_i(b), .quad_index_i(ix),
    .term_count_event_o(tc), .compare_match_event_o(cc),
    .timer_irq_o(tirq), .quad_irq_o(qirq)
  );
  quad_encoder_model enc (
    .clk_i(clk_i), .rst_i(rst_i), .step_up_i(up), .step_dn_i(dn),
    .jump_i(jmp), .a_o(a), .b_o(b)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] s,
                     input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // A wait that ran out means a hang, so the run is closed.
  task automatic hang(input int k);
    if (k >= 200) begin
      bad_count++;
      report_and_stop();
    end
  endtask

  // One classic cycle; held until ack is sampled high.
  task automatic bus(input logic w, input logic [15:0] ix,
                     input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {ix, 2'h0};
    dat_i <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 200);
    hang(k);
    r = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rd16(input logic [15:0] ix);
    bus(1'b0, ix, 8'h00);
    v[7:0] = r;
    bus(1'b0, ix + 16'h0001, 8'h00);
    v[15:8] = r;
  endtask

  // Cycles from one terminal event to the next.
  task automatic gap(output int g);
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (tc !== 1'b1 && k < 200);
    hang(k);
    g = 0;
    do begin
      @(posedge clk_i);
      g++;
    end while (tc !== 1'b1 && g < 200);
    hang(g);
  endtask

  // Encoder move: 0 up, 1 down, 2 jump; then 120 clocks, past the scale and filter settings used here.
  task automatic step(input int kind);
    @(posedge clk_i);
    up <= kind == 0;
    dn <= kind == 1;
    jmp <= kind == 2;
    @(posedge clk_i);
    up <= 1'b0;
    dn <= 1'b0;
    jmp <= 1'b0;
    repeat (120) @(posedge clk_i);
  endtask

  // Reset values, a read-only write and an unmapped hole.
  task automatic t_reset();
    logic [15:0] ro[6] = '{IDX_CAPT_R_LO, IDX_CAPT_F_HI, IDX_QUAD_CFG,
                           IDX_QUAD_CNT_HI, IDX_QUAD_MAX_LO, 16'hA053};
    bus(1'b1, IDX_CAPT_R_LO, 8'h5A);
    foreach (ro[i]) begin
      bus(1'b0, ro[i], 8'h00);
      chk("reset value", {8'h00, r}, 16'h0000);
    end
  endtask

  task automatic t_timer();
    int g;
    bus(1'b1, IDX_PERIOD_HI, 8'h00);
    bus(1'b1, IDX_PERIOD_LO, 8'h09);
    bus(1'b1, IDX_COMPARE_HI, 8'h00);
    bus(1'b1, IDX_COMPARE_LO, 8'h04);
    rd16(IDX_PERIOD_LO);
    chk("live count", v, 16'h0000);
    rd16(IDX_COMPARE_LO);
    chk("compare", v, 16'h0004);
    bus(1'b1, IDX_CAPT_CFG, 8'h80);
    bus(1'b1, IDX_TIMER_CTRL, 8'h01);
    gap(g);
    chk("period nine", 16'(g), 16'h000A);
    bus(1'b1, IDX_PERIOD_HI, 8'h00);
    bus(1'b1, IDX_PERIOD_LO, 8'h05);
    gap(g);
    chk("period five", 16'(g), 16'h0006);
    chk("timer irq", 16'(tirq), 16'h0001);
    bus(1'b1, IDX_TIMER_CTRL, 8'h00);
    bus(1'b0, IDX_TIMER_FLAGS, 8'h00);
    chk("flags set", {14'h0000, r[1:0]}, 16'h0003);
    // Enables go off while the flags still stand, so the check can trip.
    bus(1'b1, IDX_CAPT_CFG, 8'h00);
    @(posedge clk_i);
    chk("irq off", 16'(tirq), 16'h0000);
    bus(1'b1, IDX_TIMER_FLAGS, 8'h00);
    bus(1'b0, IDX_TIMER_FLAGS, 8'h00);
    chk("flags clear", {14'h0000, r[1:0]}, 16'h0000);
  endtask

  task automatic t_capture();
    rd16(IDX_PERIOD_LO);
    c = v;
    bus(1'b1, IDX_CAPT_CFG, 8'h01);
    bus(1'b0, IDX_CAPT_CFG, 8'h00);
    chk("fall trig", {8'h00, r}, 16'h0000);
    rd16(IDX_CAPT_F_LO);
    chk("capture f", v, c);
    bus(1'b1, IDX_CAPT_CFG, 8'h12);
    rd16(IDX_CAPT_R_LO);
    chk("capture r", v, c);
    rd16(IDX_PERIOD_LO);
    chk("cleared", v, 16'h0000);
    bus(1'b1, IDX_TIMER_CTRL, 8'h01);
    bus(1'b1, IDX_TIMER_CTRL, 8'h00);
    rd16(IDX_PERIOD_LO);
    c = v;
    bus(1'b1, IDX_CAPT_CFG, 8'h1C);
    ext_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd16(IDX_CAPT_R_LO);
    chk("ext rise", v, c);
    ext_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd16(IDX_CAPT_F_LO);
    chk("ext fall", v, 16'h0000);
  endtask

  // One full encoder cycle in each of the 1X, 2X and 4X modes, with scale and filter varied.
  task automatic t_modes();
    for (int m = 1; m < 4; m++) begin
      bus(1'b1, IDX_QUAD_CFG, 8'h00);
      bus(1'b1, IDX_QUAD_CNT_HI, 8'h00);
      bus(1'b1, IDX_QUAD_CNT_LO, 8'h10);
      bus(1'b1, IDX_QUAD_CFG, {m[1:0], m[1:0] - 2'h1, 1'b0, 3'(m)});
      repeat (4) step(0);
      rd16(IDX_QUAD_CNT_LO);
      chk("mode", v, 16'h0010 + (16'h0001 << (m - 1)));
    end
  endtask

  task automatic t_dir();
    bus(1'b1, IDX_QUAD_CNT_LO, 8'h77);
    rd16(IDX_QUAD_CNT_LO);
    chk("write dropped", v, 16'h0014);
    bus(1'b1, IDX_QUAD_STAT, 8'h00);
    step(1);
    bus(1'b0, IDX_QUAD_STAT, 8'h00);
    chk("dir change", {8'h00, r & 8'h82}, 16'h0002);
    step(2);
    bus(1'b0, IDX_QUAD_STAT, 8'h00);
    chk("phase error", {8'h00, r & 8'h40}, 16'h0040);
    bus(1'b1, IDX_QUAD_CFG, 8'h00);
    bus(1'b1, IDX_QUAD_CNT_HI, 8'h00);
    bus(1'b1, IDX_QUAD_CNT_LO, 8'h07);
    bus(1'b1, IDX_QUAD_MAX_LO, 8'h0A);
    bus(1'b1, IDX_QUAD_MAX_HI, 8'h80);
    bus(1'b1, IDX_QUAD_STAT, 8'h20);
    bus(1'b1, IDX_QUAD_IRQ, 8'h80);
    bus(1'b1, IDX_QUAD_CFG, 8'hC0);
    repeat (3) step(0);
    rd16(IDX_QUAD_CNT_LO);
    chk("reload", v, 16'h8000);
    bus(1'b0, IDX_QUAD_STAT, 8'h00);
    chk("terminal", {8'h00, r & 8'h08}, 16'h0008);
    chk("quad irq", 16'(qirq), 16'h0001);
    bus(1'b1, IDX_QUAD_IRQ, 8'h00);
    @(posedge clk_i);
    chk("quad irq off", 16'(qirq), 16'h0000);
    // Index with match 00 to 10 going up reloads instead of stepping.
    bus(1'b1, IDX_QUAD_STAT, 8'h10);
    bus(1'b1, IDX_QUAD_IRQ, 8'h04);
    bus(1'b1, IDX_CAPT_CFG, 8'h20);
    ix <= 1'b1;
    step(0);
    rd16(IDX_QUAD_CNT_LO);
    chk("index reload", v, 16'h8000);
    rd16(IDX_CAPT_R_LO);
    chk("coupled capture", v, 16'h0000);
  endtask

  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, ext_i, up, dn, jmp, ix} = 8'h00;
    adr_i = 18'h00000;
    sel_i = 4'hF;
    dat_i = 32'h00000000;
    bad_count = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_timer();
    t_capture();
    t_modes();
    t_dir();
    report_and_stop();
  end
endmodule

// File: dv/tcqd_checker.sv
`timescale 1ns/1ps

// Port-level checks of the bus answer, reset state and interrupt enables.
module tcqd_checker
  import tcqd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [17:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic term_count_event_o,
  input wire logic compare_match_event_o,
  input wire logic timer_irq_o,
  input wire logic quad_irq_o
);
  logic req; // A request stands on the bus.
  logic wr0; // A byte write is being acknowledged.
  assign req = cyc_i && stb_i;
  assign wr0 = req && we_i && sel_i[0] && ack_o;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_late: assert property (req && !ack_o && !$past(ack_o) |=> ack_o)
    else $error("No acknowledge one cycle after a request.");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("Acknowledge lasted more than one cycle.");
  chk_ack_cause: assert property (!req |=> !ack_o)
    else $error("Acknowledge without a request.");
  chk_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("Upper read data bits not zero.");
  chk_reset_quiet: assert property ($past(rst_i) |-> !ack_o &&
    dat_o == 32'h00000000 && !term_count_event_o &&
    !compare_match_event_o && !timer_irq_o && !quad_irq_o)
    else $error("Outputs not quiet after reset.");
  chk_hole_zero: assert property (req && !we_i && !ack_o &&
    adr_i[17:2] == 16'hA053 |=> ack_o && dat_o == 32'h00000000)
    else $error("Unmapped read did not return zero.");
  chk_timer_irq_off: assert property (
    wr0 && adr_i[17:2] == IDX_CAPT_CFG && dat_i[7:6] == 2'h0
    |=> !timer_irq_o)
    else $error("Timer interrupt high with its enables off.");
  chk_quad_irq_off: assert property (
    wr0 && adr_i[17:2] == IDX_QUAD_IRQ && dat_i[7:3] == 5'h00
    |=> !quad_irq_o)
    else $error("Decoder interrupt high with its enables off.");

  cover property (term_count_event_o);
  cover property (compare_match_event_o);
  cover property ($rose(timer_irq_o));
  cover property ($rose(quad_irq_o));
endmodule

bind timer_capture_quad_decoder tcqd_checker chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .term_count_event_o(term_count_event_o),
  .compare_match_event_o(compare_match_event_o),
  .timer_irq_o(timer_irq_o), .quad_irq_o(quad_irq_o)
);
